// [dv/ddrri_mem_model.sv]
/*
 * far-side memory model: makes the free-running command clock and logs each command.
 * assumes commands are one-cycle pulses on ref_clk, as the sequencer issues them.
 */
`timescale 1ns/1ns
module ddrri_mem_model
    import ddrri_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic [2:0]      mem_cmd,
    input  wire logic [2:0]      mem_ba,
    input  wire logic [MA_W-1:0] mem_addr,
    output logic                 link_clk
);
    logic [MA_W-1:0] mode_regs [4];
    logic [7:0]      cmd_log [$];

    // odd offset keeps the command clock out of phase with ref_clk
    initial begin
        link_clk = 1'b0;
        #37;
        forever #200 link_clk = ~link_clk;
    end

    always @(posedge ref_clk) begin
        if (mem_cmd != DDRRI_CMD_NOP) begin
            cmd_log.push_back({2'b00, mem_cmd, mem_ba});
        end
        if (mem_cmd == DDRRI_CMD_MRS) begin
            mode_regs[mem_ba[1:0]] <= mem_addr;
        end
    end
endmodule : ddrri_mem_model

// [dv/ddrri_properties.sv]
/*
 * port checker of the ddr2 reset and initialization sequencer.
 * assumes it is bound to ddrri_top; only rst is seen as reset, other sources hold outputs quiet.
 */
`timescale 1ns/1ns
module ddrri_properties
    import ddrri_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic            avs_waitrequest,
    input wire logic [2:0]      mem_cmd,
    input wire logic [2:0]      mem_ba,
    input wire logic [MA_W-1:0] mem_addr,
    input wire logic            init_busy,
    input wire logic            irq,
    input wire logic            dma_event
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_NO_IRQ: assert property (irq == 1'b0)
        else $error("interrupt request raised");
    AST_NO_DMA: assert property (dma_event == 1'b0)
        else $error("dma event raised");
    AST_ANSWER_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_read | avs_write))
        else $error("answer without request");
    AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held over two cycles");
    AST_MODE_WORD: assert property (mem_cmd == DDRRI_CMD_MRS && mem_ba == BA_MR
        |-> mem_addr[12] == 1'b0 && mem_addr[8:7] == 2'h0 && mem_addr[3:0] == 4'h3)
        else $error("mode word fixed bits wrong");
    AST_EMR1_WORD: assert property (mem_cmd == DDRRI_CMD_MRS && mem_ba == BA_EMR1
        |-> mem_addr[12:3] == 10'h000 && mem_addr[2] == 1'b1 && mem_addr[0] == 1'b0)
        else $error("extended mode 1 word wrong");
    AST_EMR23_ZERO: assert property (mem_cmd == DDRRI_CMD_MRS && mem_ba[1]
        |-> mem_addr == EMR_ZERO)
        else $error("extended mode 2 or 3 not zero");
    AST_PALL_ALL: assert property (mem_cmd == DDRRI_CMD_PALL |-> mem_addr[10])
        else $error("precharge not to all banks");
    AST_AREF_END: assert property (mem_cmd == DDRRI_CMD_AREF |-> ##[1:4] !init_busy)
        else $error("busy stays after auto-refresh");
    AST_CMD_PULSE: assert property (mem_cmd != DDRRI_CMD_NOP |=> mem_cmd == DDRRI_CMD_NOP)
        else $error("command longer than one cycle");
endmodule : ddrri_properties

bind ddrri_top ddrri_properties u_ddrri_properties (.ref_clk(ref_clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .mem_cmd(mem_cmd), .mem_ba(mem_ba), .mem_addr(mem_addr), .init_busy(init_busy),
    .irq(irq), .dma_event(dma_event));

// [dv/tb_ddr2_reset_init_sequencer.sv]
/*
 * self-checking bench of ddrri_top: register bus, reset sources and mode words seen by memory.
 * assumes the memory model logs commands; expected values come from a register model here.
 */
`timescale 1ns/1ns
module tb_ddr2_reset_init_sequencer
    import ddrri_pkg::*;
;
    logic ref_clk = 1'b0, access_pending = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] hrs = 4'h1, avs_byteenable = 4'h0;
    logic [1:0] srs = 2'h0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, cfg, tim1;
    logic avs_waitrequest, queue_flush, init_busy, hold_access, irq, dma_event, link_clk;
    logic [2:0] mem_cmd, mem_ba, read_latency_sel, cl, wrv;
    logic [MA_W-1:0] mem_addr;
    int err_total = 0, num_checks = 0;

    always #25 ref_clk = ~ref_clk;

    ddrri_top u_ddrri_top (.ref_clk(ref_clk), .rst(hrs[0]), .ce(1'b1), .por_rst(hrs[1]),
        .warm_rst(hrs[2]), .max_rst(hrs[3]), .sys_rst(srs[0]), .cpu_rst(srs[1]),
        .link_clk(link_clk), .access_pending(access_pending), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
        .mem_addr(mem_addr), .queue_flush(queue_flush), .init_busy(init_busy),
        .hold_access(hold_access), .read_latency_sel(read_latency_sel), .irq(irq),
        .dma_event(dma_event));
    ddrri_mem_model u_ddrri_mem_model (.ref_clk(ref_clk), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
        .mem_addr(mem_addr), .link_clk(link_clk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        // the wait itself is unbounded; the answer must still come one cycle after the request
        chk(n, 2);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(q, exp);
    endtask : rd

    // waits for the sequence, then compares the command order and each mode word
    task automatic chk_init();
        logic [7:0] seq [6];
        int n;
        seq = '{8'h08, 8'h12, 8'h13, 8'h11, 8'h10, 8'h18};
        n = 0;
        repeat (6) @(posedge ref_clk);
        while (init_busy !== 1'b0 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n < 600, 1'b1);
        // let the model log the closing refresh before the log is read
        @(posedge ref_clk);
        chk(u_ddrri_mem_model.cmd_log.size(), 6);
        for (int i = 0; i < 6; i++) chk(u_ddrri_mem_model.cmd_log[i], seq[i]);
        chk(u_ddrri_mem_model.mode_regs[0], {1'b0, tim1[21:19], 2'b00, cfg[11:9], 4'h3});
        chk(u_ddrri_mem_model.mode_regs[1], {10'h000, 1'b1, cfg[18], 1'b0});
        chk(u_ddrri_mem_model.mode_regs[2] | u_ddrri_mem_model.mode_regs[3], 0);
        chk({irq, dma_event, hold_access}, 0);
        u_ddrri_mem_model.cmd_log.delete();
    endtask : chk_init

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #1000000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(26));
        cfg = CONFIG_RST;
        tim1 = TIM1_RST;
        repeat (20) @(posedge ref_clk);
        hrs <= 4'h0;
        chk_init();
        rd(OFF_CONFIG, CONFIG_RST);
        rd(OFF_STATUS, 32'h0000_0002);
        rd(5'h1c, 32'h0);
        cl = 3'($urandom);
        wrv = 3'($urandom);
        // reconfiguration in the software order; boot key toggles the drive bit
        bus(1'b1, OFF_CONFIG, 32'h0080_0000, 4'h4);
        bus(1'b1, OFF_CONFIG, 32'h0004_0000, 4'h4);
        cfg = {16'h0004, 1'b1, 3'h0, cl, 9'h032};
        bus(1'b1, OFF_CONFIG, cfg, 4'h3);
        chk_init();
        bus(1'b1, OFF_TIM1, 32'(wrv) << 19, 4'hf);
        bus(1'b1, OFF_REFR, 32'h0000_05a5, 4'hf);
        cfg[15] = 1'b0;
        bus(1'b1, OFF_CONFIG, cfg, 4'h3);
        tim1 = 32'(wrv) << 19;
        chk_init();
        bus(1'b1, OFF_TIM1, ~tim1, 4'hf);
        rd(OFF_TIM1, tim1);
        rd(OFF_CONFIG, cfg);
        bus(1'b1, OFF_CTRL, 32'(cl), 4'hf);
        // register lands at the answer edge, the output copy one edge later
        repeat (2) @(posedge ref_clk);
        chk(read_latency_sel, cl);
        // pending accesses must drain before the sequence starts
        access_pending <= 1'b1;
        bus(1'b1, OFF_CONFIG, cfg, 4'h1);
        repeat (80) @(posedge ref_clk);
        chk(u_ddrri_mem_model.cmd_log.size(), 0);
        chk({init_busy, queue_flush, hold_access}, 3'b100);
        access_pending <= 1'b0;
        chk_init();
        for (int i = 0; i < 2; i++) begin
            srs[i] <= 1'b1;
            repeat (4) @(posedge ref_clk);
            avs_address <= OFF_CONFIG;
            avs_read <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk({avs_waitrequest, queue_flush, hold_access}, 3'b111);
            avs_read <= 1'b0;
            srs[i] <= 1'b0;
            chk_init();
            rd(OFF_CONFIG, cfg);
            rd(OFF_TIM1, tim1);
        end
        for (int i = 1; i < 4; i++) begin
            bus(1'b1, OFF_REFR, 32'h0000_00aa, 4'hf);
            hrs[i] <= 1'b1;
            repeat (3) @(posedge ref_clk);
            chk(queue_flush, 1'b1);
            hrs <= 4'h0;
            u_ddrri_mem_model.cmd_log.delete();
            cfg = CONFIG_RST;
            tim1 = TIM1_RST;
            chk_init();
            rd(OFF_REFR, REFR_RST);
            rd(OFF_CONFIG, CONFIG_RST);
        end
        stop_test();
    end
endmodule : tb_ddr2_reset_init_sequencer

// [rtl/ddrri_mode_calc.sv]
/*
 * builds the mode register and extended mode register 1 words from configuration.
 * purely combinational; the caller registers the result before it leaves the block.
 */
`timescale 1ns/1ns
module ddrri_mode_calc
    import ddrri_pkg::*;
(
    input  wire logic [2:0]      wr_recovery,
    input  wire logic [2:0]      cas_latency_field,
    input  wire logic            drive_strength,
    output logic      [MA_W-1:0] mode_word,
    output logic      [MA_W-1:0] emr1_word
);
    // fast exit, no dll reset, normal mode, sequential burst of eight
    assign mode_word = {1'b0, wr_recovery, 1'b0, 1'b0, cas_latency_field, 1'b0, MR_BURST8};

    // buffers on, dll on, fixed termination, drive from configuration
    assign emr1_word = {3'b000, EMR1_OCD, 1'b0, EMR1_AL, 1'b1, drive_strength, 1'b0};

endmodule : ddrri_mode_calc

// [rtl/ddrri_pkg.sv]
/*
 * constants, register map and types of the reset and initialization sequencer
 * of a ddr2 sdram controller.
 * assumes a 32-bit avalon-mm register bus with byte addresses and a 13-bit memory address.
 */
package ddrri_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned MA_W   = 13;

    // register byte offsets
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_CONFIG = 5'h08;
    localparam logic [4:0] OFF_REFR   = 5'h0c;
    localparam logic [4:0] OFF_TIM1   = 5'h10;
    localparam logic [4:0] OFF_TIM2   = 5'h14;
    localparam logic [4:0] OFF_CTRL   = 5'h18;

    // sdram_config_reg fields
    localparam int unsigned CFG_CL_LSB   = 9;
    localparam int unsigned CFG_KEY_BIT  = 15;
    localparam int unsigned CFG_DRV_BIT  = 18;
    localparam int unsigned CFG_BOOT_BIT = 23;
    localparam int unsigned CFG_W        = 24;
    // timing_reg_one write recovery field
    localparam int unsigned TIM1_WR_LSB  = 19;
    // refresh_control_reg rate field width, controller_control_reg latency width
    localparam int unsigned RFC_W        = 16;
    localparam int unsigned RL_W         = 3;

    // reset values
    localparam logic [31:0] CONFIG_RST = 32'h0000_0832;
    localparam logic [31:0] TIM1_RST   = 32'h0000_0000;
    localparam logic [31:0] TIM2_RST   = 32'h0000_0000;
    localparam logic [31:0] REFR_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

    // status bits
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_PEND_BIT = 2;

    // fixed mode register bits
    localparam logic [2:0] MR_BURST8   = 3'h3;
    localparam logic [2:0] EMR1_OCD    = 3'h0;
    localparam logic [2:0] EMR1_AL     = 3'h0;
    localparam logic [MA_W-1:0] EMR_ZERO = 13'h0000;

    // bank select of each mode register
    localparam logic [2:0] BA_MR   = 3'h0;
    localparam logic [2:0] BA_EMR1 = 3'h1;
    localparam logic [2:0] BA_EMR2 = 3'h2;
    localparam logic [2:0] BA_EMR3 = 3'h3;
    // a10 high on precharge selects all banks
    localparam logic [MA_W-1:0] PALL_ADDR = 13'h0400;

    typedef enum logic [2:0] {
        DDRRI_CMD_NOP  = 3'h0,
        DDRRI_CMD_PALL = 3'h1,
        DDRRI_CMD_MRS  = 3'h2,
        DDRRI_CMD_AREF = 3'h3
    } ddrri_cmd_e;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_DRAIN = 8'h02,
        ST_PALL  = 8'h04,
        ST_EMR2  = 8'h08,
        ST_EMR3  = 8'h10,
        ST_EMR1  = 8'h20,
        ST_MR    = 8'h40,
        ST_AREF  = 8'h80
    } ddrri_state_e;

endpackage : ddrri_pkg

// [rtl/ddrri_sync.sv]
/*
 * two flip-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level; no multi-bit coherency is provided.
 */
`timescale 1ns/1ns
module ddrri_sync
    import ddrri_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta[i]     <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (ce) begin
                    meta[i]     <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : ddrri_sync

// [rtl/ddrri_top.sv]
/*
 * reset handling, register file and power-up initialization of a ddr2 controller.
 * assumes: the command scheduler reports pending accesses on same-clock access_pending and
 * discards its queues on queue_flush; link_clk is the memory command clock, sampled here.
 */
`timescale 1ns/1ns
module ddrri_top
    import ddrri_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              por_rst,
    input  wire logic              warm_rst,
    input  wire logic              max_rst,
    input  wire logic              sys_rst,
    input  wire logic              cpu_rst,
    input  wire logic              link_clk,
    input  wire logic              access_pending,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic      [2:0]        mem_cmd,
    output logic      [2:0]        mem_ba,
    output logic      [MA_W-1:0]   mem_addr,
    output logic                   queue_flush,
    output logic                   init_busy,
    output logic                   hold_access,
    output logic      [RL_W-1:0]   read_latency_sel,
    output logic                   irq,
    output logic                   dma_event
);

    logic                hard_rst;
    logic [1:0]          soft_src;
    logic                soft_rst;
    logic                link_s;
    logic                link_q;
    logic                link_rise;
    logic                soft_q;
    logic                soft_fall;

    logic [31:0]         sdram_config_reg;
    logic [31:0]         timing_reg_one;
    logic [31:0]         timing_reg_two;
    logic [31:0]         refresh_control_reg;
    logic [31:0]         controller_control_reg;

    logic                acc_take;
    logic                wr_take;
    logic [31:0]         next_readdata;
    logic [31:0]         wmask;
    logic                cfg_low_write;

    ddrri_state_e        state;
    ddrri_state_e        next_state;
    logic                init_req;
    logic                init_from_cfg;
    logic                init_done;
    logic [MA_W-1:0]     mode_word;
    logic [MA_W-1:0]     emr1_word;

    // any of the four chip resets clears everything, asynchronously
    assign hard_rst = rst | por_rst | warm_rst | max_rst;

    ddrri_sync #(.W(2)) u_soft_sync (
        .ref_clk  (ref_clk),
        .rst      (hard_rst),
        .ce       (ce),
        .async_in ({sys_rst, cpu_rst}),
        .sync_out (soft_src)
    );

    assign soft_rst = |soft_src;

    // link clock is only sampled; commands step on its rising edges
    ddrri_sync #(.W(1)) u_link_sync (
        .ref_clk  (ref_clk),
        .rst      (hard_rst),
        .ce       (ce),
        .async_in (link_clk),
        .sync_out (link_s)
    );

    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            link_q <= 1'b0;
            soft_q <= 1'b0;
        end else if (ce) begin
            link_q <= link_s;
            soft_q <= soft_rst;
        end
    end

    assign link_rise = link_s & ~link_q;
    assign soft_fall = soft_q & ~soft_rst;

    // byte-enable mask for partial writes
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{avs_byteenable[b]}};
        end
    endgenerate

    // request is accepted one cycle after it appears; none while a reset stands
    assign acc_take = (avs_read | avs_write) & avs_waitrequest & ~soft_rst;
    assign wr_take  = avs_write & ~avs_waitrequest & ~soft_rst;
    assign cfg_low_write = wr_take && (avs_address == OFF_CONFIG)
                        && (|avs_byteenable[1:0]);

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            OFF_STATUS: begin
                next_readdata[ST_BUSY_BIT] = init_busy;
                next_readdata[ST_DONE_BIT] = init_done;
                next_readdata[ST_PEND_BIT] = access_pending;
            end
            OFF_CONFIG: next_readdata = sdram_config_reg;
            OFF_REFR:   next_readdata = refresh_control_reg;
            OFF_TIM1:   next_readdata = timing_reg_one;
            OFF_TIM2:   next_readdata = timing_reg_two;
            OFF_CTRL:   next_readdata = controller_control_reg;
            default:    next_readdata = 32'h0000_0000;
        endcase
    end

    // bus handshake; hard reset forces waitrequest high, soft reset holds it high
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if (acc_take) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // configuration survives a soft reset; only hard reset clears it
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            sdram_config_reg <= CONFIG_RST;
        end else if (ce && wr_take && avs_address == OFF_CONFIG) begin
            sdram_config_reg <= (sdram_config_reg & ~wmask) | (avs_writedata & wmask);
            // drive strength moves only on the write that drops the boot key
            if (!(sdram_config_reg[CFG_BOOT_BIT] && avs_byteenable[CFG_DRV_BIT/8]
                  && !avs_writedata[CFG_BOOT_BIT])) begin
                sdram_config_reg[CFG_DRV_BIT] <= sdram_config_reg[CFG_DRV_BIT];
            end
            sdram_config_reg[31:CFG_W] <= '0;
        end
    end

    // timing registers are locked unless the key is set
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            timing_reg_one <= TIM1_RST;
            timing_reg_two <= TIM2_RST;
        end else if (ce && wr_take && sdram_config_reg[CFG_KEY_BIT]) begin
            if (avs_address == OFF_TIM1) begin
                timing_reg_one <= (timing_reg_one & ~wmask) | (avs_writedata & wmask);
            end
            if (avs_address == OFF_TIM2) begin
                timing_reg_two <= (timing_reg_two & ~wmask) | (avs_writedata & wmask);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            refresh_control_reg    <= REFR_RST;
            controller_control_reg <= CTRL_RST;
        end else if (ce && wr_take) begin
            if (avs_address == OFF_REFR) begin
                refresh_control_reg <= (refresh_control_reg & ~wmask)
                                     | (avs_writedata & wmask & {{(32-RFC_W){1'b0}},
                                                                 {RFC_W{1'b1}}});
            end
            if (avs_address == OFF_CTRL) begin
                controller_control_reg <= (controller_control_reg & ~wmask)
                                        | (avs_writedata & wmask
                                           & {{(32-RL_W){1'b0}}, {RL_W{1'b1}}});
            end
        end
    end

    // values come from registers as they currently stand, also after a soft reset
    ddrri_mode_calc u_mode (
        .wr_recovery       (timing_reg_one[TIM1_WR_LSB +: 3]),
        .cas_latency_field (sdram_config_reg[CFG_CL_LSB +: 3]),
        .drive_strength    (sdram_config_reg[CFG_DRV_BIT]),
        .mode_word         (mode_word),
        .emr1_word         (emr1_word)
    );

    // pending start: set by reset or a configuration write enabling byte 0 or byte 1
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            init_req      <= 1'b1;
            init_from_cfg <= 1'b0;
        end else if (ce) begin
            if (soft_rst) begin
                init_req      <= 1'b1;
                init_from_cfg <= 1'b0;
            end else if (cfg_low_write) begin
                init_req      <= 1'b1;
                init_from_cfg <= 1'b1;
            end else if (state == ST_IDLE && init_req) begin
                init_req <= 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (init_req) begin
                    next_state = init_from_cfg ? ST_DRAIN : ST_PALL;
                end
            end
            ST_DRAIN: begin
                if (!access_pending) begin
                    next_state = ST_PALL;
                end
            end
            ST_PALL: if (link_rise) next_state = ST_EMR2;
            ST_EMR2: if (link_rise) next_state = ST_EMR3;
            ST_EMR3: if (link_rise) next_state = ST_EMR1;
            ST_EMR1: if (link_rise) next_state = ST_MR;
            ST_MR:   if (link_rise) next_state = ST_AREF;
            ST_AREF: if (link_rise) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            state <= ST_IDLE;
        end else if (ce) begin
            if (soft_rst) begin
                state <= ST_IDLE;
            end else begin
                state <= next_state;
            end
        end
    end

    // one command per link edge; nop between them
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            mem_cmd  <= DDRRI_CMD_NOP;
            mem_ba   <= 3'h0;
            mem_addr <= '0;
        end else if (ce) begin
            mem_cmd  <= DDRRI_CMD_NOP;
            mem_ba   <= 3'h0;
            mem_addr <= '0;
            if (!soft_rst && link_rise) begin
                unique case (state)
                    ST_PALL: begin
                        mem_cmd  <= DDRRI_CMD_PALL;
                        mem_addr <= PALL_ADDR;
                    end
                    ST_EMR2: begin
                        mem_cmd  <= DDRRI_CMD_MRS;
                        mem_ba   <= BA_EMR2;
                        mem_addr <= EMR_ZERO;
                    end
                    ST_EMR3: begin
                        mem_cmd  <= DDRRI_CMD_MRS;
                        mem_ba   <= BA_EMR3;
                        mem_addr <= EMR_ZERO;
                    end
                    ST_EMR1: begin
                        mem_cmd  <= DDRRI_CMD_MRS;
                        mem_ba   <= BA_EMR1;
                        mem_addr <= emr1_word;
                    end
                    ST_MR: begin
                        mem_cmd  <= DDRRI_CMD_MRS;
                        mem_ba   <= BA_MR;
                        mem_addr <= mode_word;
                    end
                    ST_AREF: mem_cmd <= DDRRI_CMD_AREF;
                    default: mem_cmd <= DDRRI_CMD_NOP;
                endcase
            end
        end
    end

    // queues are flushed on reset so stale traffic never reaches the memory
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            queue_flush <= 1'b1;
        end else if (ce) begin
            queue_flush <= soft_rst;
        end
    end

    // scheduler stops taking new accesses once a reset start is pending; a configured start holds it only after the drain
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            init_busy   <= 1'b1;
            hold_access <= 1'b1;
            init_done   <= 1'b0;
        end else if (ce) begin
            init_busy   <= soft_rst | init_req | (next_state != ST_IDLE);
            hold_access <= soft_rst | (next_state != ST_IDLE && next_state != ST_DRAIN)
                         | (init_req & ~init_from_cfg);
            if (soft_rst || soft_fall || cfg_low_write) begin
                init_done <= 1'b0;
            end else if (state == ST_AREF && link_rise) begin
                init_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            read_latency_sel <= CTRL_RST[RL_W-1:0];
        end else if (ce) begin
            read_latency_sel <= controller_control_reg[RL_W-1:0];
        end
    end

    // never an interrupt and never a dma trigger; no halt input, so debug access is unaffected
    always_ff @(posedge ref_clk or posedge hard_rst) begin
        if (hard_rst) begin
            irq       <= 1'b0;
            dma_event <= 1'b0;
        end else if (ce) begin
            irq       <= 1'b0;
            dma_event <= 1'b0;
        end
    end

endmodule : ddrri_top
